// File: design/gcsd_decoder.sv
/*
  Gauge control subcommand decoder: I2C slave front end for the control word
  command and the subcommand decode, status flags and calibration timers.
  Assumes SCL/SDA arrive asynchronously and the core measurement logic sits
  outside, feeding the core_in struct on the system clock.
*/
`timescale 1ns/10ps

module gcsd_decoder
  import gcsd_pkg::*;
#(
  parameter longint unsigned CCA_DELAY = CCA_CYC,
  parameter longint unsigned BCAL_TIME = BCAL_CYC,
  parameter longint unsigned ICAL_TIME = ICAL_CYC
) (
  // Clock and reset
  input  wire logic          sys_clk_in,
  input  wire logic          rst_n_in,
  // I2C pins
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe_n_out,
  // Core measurement side
  input  gcsd_core_in_t      core_in,
  // Actions to the core
  output logic               flash_sum_start_out,
  output logic               oc_sample_req_out,
  output logic               restore_out,
  output logic               cal_mode_out,
  output logic               full_reset_out,
  output logic               offset_store_out,
  output logic               pack_present_flag_out,
  output logic [15:0]        control_status_word_out
);

  typedef struct packed {
    logic [1:0]    scl_s;
    logic [1:0]    sda_s;
    logic          scl_d;
    logic          sda_d;
    gcsd_link_st_t st;
    logic [3:0]    bitn;
    logic [7:0]    sh;
    logic          rd;
    logic [1:0]    nbyte;
    logic [7:0]    ptr;
    logic [15:0]   sub;
    logic [15:0]   prev_sub;
    logic [15:0]   ret;
    logic          sda_o;
    logic          sda_oe_n;
    gcsd_flags_t   fl;
    logic          pack;
    logic [15:0]   sum_store;
    logic [15:0]   board_store;
    logic [15:0]   ofs_store;
    logic [31:0]   cca_cnt;
    logic [31:0]   cal_cnt;
    logic          bcal_run;
    logic          ical_run;
    logic          sum_go;
    logic          oc_req;
    logic          oc_wait;
    logic          rest;
    logic          calm;
    logic          frst;
    logic          ostore;
  } gcsd_state_t;

  gcsd_state_t s_ff;
  gcsd_state_t nxt_s;

  function automatic logic [15:0] pack_status(input gcsd_flags_t f);
    pack_status = {1'b0, f.full_locked, f.locked, f.sum_valid, f.counter_cal_active,
                   f.board_cal_active, f.open_circuit_done, f.open_circuit_fail,
                   f.init_done, f.deep_sleep_req, f.light_sleep_enabled, f.sleep,
                   f.constant_power_mode, f.resistance_update_disable,
                   f.voltage_ok_for_capacity, f.capacity_update_enable};
  endfunction

  function automatic logic locked_ok(input logic [15:0] c);
    locked_ok = (c <= SUB_SI_REV) || (c == SUB_CHEM) ||
                (c >= SUB_OC_SAMPLE && c <= SUB_PACK_OUT) ||
                (c >= SUB_DS_SET && c <= SUB_LS_CLR);
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [15:0] status_w;

  always_comb begin
    scl_rise = s_ff.scl_s[1] & ~s_ff.scl_d;
    scl_fall = ~s_ff.scl_s[1] & s_ff.scl_d;
    start_c  = s_ff.scl_s[1] & s_ff.sda_d & ~s_ff.sda_s[1];
    stop_c   = s_ff.scl_s[1] & ~s_ff.sda_d & s_ff.sda_s[1];
    status_w = pack_status(s_ff.fl);
  end

  always_comb begin
    logic [15:0] c;
    logic        exec;
    c     = 16'h0000;
    exec  = 1'b0;
    nxt_s = s_ff;
    nxt_s.scl_s = {s_ff.scl_s[0], scl_in};
    nxt_s.sda_s = {s_ff.sda_s[0], sda_in};
    nxt_s.scl_d = s_ff.scl_s[1];
    nxt_s.sda_d = s_ff.sda_s[1];
    nxt_s.sum_go = 1'b0;
    nxt_s.oc_req = 1'b0;
    nxt_s.rest   = 1'b0;
    nxt_s.calm   = 1'b0;
    nxt_s.frst   = 1'b0;
    nxt_s.ostore = 1'b0;

    // Live status inputs
    nxt_s.fl.init_done                 = core_in.init_done;
    nxt_s.fl.sleep                     = core_in.sleep;
    nxt_s.fl.constant_power_mode       = core_in.constant_power_mode;
    nxt_s.fl.resistance_update_disable = core_in.resistance_update_disable;
    if (core_in.voltage_bad) begin
      nxt_s.fl.voltage_ok_for_capacity = 1'b0;
    end
    if (core_in.insertion_detect_enable) begin
      nxt_s.pack = core_in.pack_detect;
    end

    // Counter calibration window after init
    if (!s_ff.fl.init_done) begin
      nxt_s.cca_cnt = 32'h0000_0000;
      nxt_s.fl.counter_cal_active = 1'b0;
    end else if (s_ff.cca_cnt < 32'(CCA_DELAY + CCA_RUN_CYC)) begin
      nxt_s.cca_cnt = s_ff.cca_cnt + 32'h0000_0001;
      nxt_s.fl.counter_cal_active = (s_ff.cca_cnt >= 32'(CCA_DELAY));
    end else begin
      nxt_s.fl.counter_cal_active = 1'b0;
    end

    // Open-circuit sample completion
    if (s_ff.oc_wait && (core_in.oc_sample_ok || core_in.oc_sample_high_current)) begin
      nxt_s.oc_wait = 1'b0;
      nxt_s.fl.open_circuit_done = s_ff.pack;
      nxt_s.fl.open_circuit_fail = core_in.oc_sample_high_current;
    end

    // Offset calibration timers
    if (s_ff.bcal_run || s_ff.ical_run) begin
      nxt_s.cal_cnt = s_ff.cal_cnt + 32'h0000_0001;
      if (s_ff.bcal_run && s_ff.cal_cnt == 32'(BCAL_TIME - 1)) begin
        nxt_s.bcal_run    = 1'b0;
        nxt_s.board_store = core_in.board_offset_meas;
        nxt_s.ret         = core_in.board_offset_meas;
        nxt_s.fl.board_cal_active = 1'b1;
      end
      if (s_ff.ical_run && s_ff.cal_cnt == 32'(ICAL_TIME - 1)) begin
        nxt_s.ical_run  = 1'b0;
        nxt_s.ofs_store = core_in.counter_offset_meas;
        nxt_s.ret       = core_in.counter_offset_meas;
      end
    end

    // I2C slave
    if (start_c) begin
      nxt_s.st = LS_ADDR;
      nxt_s.bitn = 4'h0;
      nxt_s.nbyte = 2'h0;
      nxt_s.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      nxt_s.st = LS_IDLE;
      nxt_s.sda_oe_n = 1'b1;
      if (s_ff.nbyte == 2'h3 && !s_ff.rd && s_ff.ptr == CMD_CTRL_LO) begin
        exec = 1'b1;
        c    = s_ff.sub;
      end
    end else begin
      unique case (s_ff.st)
        LS_IDLE: begin
          nxt_s.sda_oe_n = 1'b1;
        end
        LS_ADDR, LS_DATA: begin
          if (scl_rise) begin
            nxt_s.sh = {s_ff.sh[6:0], s_ff.sda_s[1]};
            nxt_s.bitn = s_ff.bitn + 4'h1;
          end
          if (scl_fall && s_ff.bitn == 4'h8) begin
            nxt_s.bitn = 4'h0;
            if (s_ff.st == LS_ADDR && s_ff.sh[7:1] != DEV_ADDR) begin
              nxt_s.st = LS_IDLE;
            end else begin
              nxt_s.st = LS_ACK;
              nxt_s.sda_o = 1'b0;
              nxt_s.sda_oe_n = 1'b0;
              if (s_ff.st == LS_ADDR) begin
                nxt_s.rd = s_ff.sh[0];
                nxt_s.nbyte = 2'h0;
              end else begin
                unique case (s_ff.nbyte)
                  2'h0: nxt_s.ptr = s_ff.sh;
                  2'h1: nxt_s.sub[7:0] = s_ff.sh;
                  default: nxt_s.sub[15:8] = s_ff.sh;
                endcase
                if (s_ff.nbyte != 2'h3) begin
                  nxt_s.nbyte = s_ff.nbyte + 2'h1;
                end
              end
            end
          end
        end
        LS_ACK: begin
          if (scl_fall) begin
            nxt_s.sda_oe_n = 1'b1;
            if (s_ff.rd && s_ff.nbyte == 2'h0 && s_ff.st == LS_ACK && s_ff.bitn == 4'h0
                && s_ff.sh[0]) begin
              nxt_s.st = LS_TX;
              nxt_s.sh = (s_ff.ptr[0]) ? s_ff.ret[15:8] : s_ff.ret[7:0];
              nxt_s.sda_o = (s_ff.ptr[0]) ? s_ff.ret[15] : s_ff.ret[7];
              nxt_s.sda_oe_n = 1'b0;
              nxt_s.bitn = 4'h1;
            end else begin
              nxt_s.st = LS_DATA;
            end
          end
        end
        LS_TX: begin
          if (scl_fall) begin
            if (s_ff.bitn == 4'h8) begin
              nxt_s.st = LS_TACK;
              nxt_s.sda_oe_n = 1'b1;
              nxt_s.ptr = s_ff.ptr + 8'h01;
            end else begin
              nxt_s.sda_o = s_ff.sh[3'(7 - s_ff.bitn)];
              nxt_s.bitn = s_ff.bitn + 4'h1;
            end
          end
        end
        LS_TACK: begin
          if (scl_rise && s_ff.sda_s[1]) begin
            nxt_s.st = LS_IDLE;
          end else if (scl_fall) begin
            nxt_s.st = LS_TX;
            nxt_s.sh = (s_ff.ptr[0]) ? s_ff.ret[15:8] : s_ff.ret[7:0];
            nxt_s.sda_o = (s_ff.ptr[0]) ? s_ff.ret[15] : s_ff.ret[7];
            nxt_s.sda_oe_n = 1'b0;
            nxt_s.bitn = 4'h1;
          end
        end
        default: nxt_s.st = LS_IDLE;
      endcase
    end

    // Subcommand decode
    if (exec && (!s_ff.fl.locked || locked_ok(c))) begin
      nxt_s.prev_sub = c;
      unique case (c)
        SUB_STATUS: nxt_s.ret = status_w;
        SUB_PART:   nxt_s.ret = PART_KIND_VAL;
        SUB_FW_REV: nxt_s.ret = FW_REV_VAL;
        SUB_SI_REV: nxt_s.ret = SI_REV_VAL;
        SUB_SUM: begin
          nxt_s.sum_go = 1'b1;
          nxt_s.sum_store = core_in.flash_sum;
          nxt_s.ret = core_in.flash_sum;
          nxt_s.fl.sum_valid = 1'b1;
        end
        SUB_ECHO: nxt_s.ret = s_ff.prev_sub;
        SUB_CHEM: nxt_s.ret = CHEMISTRY_ID_QUERY_VAL;
        SUB_BOARD_CAL: begin
          nxt_s.bcal_run = 1'b1;
          nxt_s.cal_cnt = 32'h0000_0000;
        end
        SUB_INT_CAL: begin
          nxt_s.ical_run = 1'b1;
          nxt_s.cal_cnt = 32'h0000_0000;
        end
        SUB_OFS_STORE: nxt_s.ostore = 1'b1;
        SUB_OC_SAMPLE: begin
          nxt_s.oc_req = 1'b1;
          nxt_s.oc_wait = 1'b1;
        end
        SUB_PACK_IN: if (!core_in.insertion_detect_enable) nxt_s.pack = 1'b1;
        SUB_PACK_OUT: if (!core_in.insertion_detect_enable) nxt_s.pack = 1'b0;
        SUB_DS_SET: nxt_s.fl.deep_sleep_req = 1'b1;
        SUB_DS_CLR: nxt_s.fl.deep_sleep_req = 1'b0;
        SUB_LS_SET: nxt_s.fl.light_sleep_enabled = 1'b1;
        SUB_LS_CLR: nxt_s.fl.light_sleep_enabled = 1'b0;
        SUB_RESTORE: nxt_s.rest = 1'b1;
        SUB_LOCK: nxt_s.fl.locked = 1'b1;
        SUB_ALG_EN: begin
          nxt_s.fl.voltage_ok_for_capacity = 1'b1;
          nxt_s.fl.capacity_update_enable = 1'b1;
        end
        SUB_CAL_MODE: nxt_s.calm = 1'b1;
        SUB_RESET: nxt_s.frst = 1'b1;
        default: nxt_s.prev_sub = s_ff.prev_sub;
      endcase
    end else if (exec && c == SUB_SUM) begin
      nxt_s.ret = s_ff.sum_store;
    end else if (exec && c == SUB_BOARD_CAL) begin
      nxt_s.ret = s_ff.board_store;
    end else if (exec && c == SUB_INT_CAL) begin
      nxt_s.ret = s_ff.ofs_store;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
      s_ff.scl_s <= 2'h3;
      s_ff.sda_s <= 2'h3;
      s_ff.scl_d <= 1'b1;
      s_ff.sda_d <= 1'b1;
      s_ff.sda_o <= 1'b1;
      s_ff.sda_oe_n <= 1'b1;
      s_ff.ret <= RST_WORD;
      s_ff.st <= LS_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_comb begin
    sda_out                 = s_ff.sda_o;
    sda_oe_n_out            = s_ff.sda_oe_n;
    flash_sum_start_out     = s_ff.sum_go;
    oc_sample_req_out       = s_ff.oc_req;
    restore_out             = s_ff.rest;
    cal_mode_out            = s_ff.calm;
    full_reset_out          = s_ff.frst;
    offset_store_out        = s_ff.ostore;
    pack_present_flag_out   = s_ff.pack;
    control_status_word_out = s_ff.ret;
  end

  lock_sticky_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_ff.fl.locked |=> s_ff.fl.locked) else $error("lock dropped");
  locked_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (exec_view() && s_ff.fl.locked && s_ff.sub == SUB_RESTORE) |=> !restore_out)
    else $error("restore while locked");
  ds_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (exec_view() && s_ff.sub == SUB_DS_SET) |=> s_ff.fl.deep_sleep_req)
    else $error("deep sleep not set");
  ls_clr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (exec_view() && s_ff.sub == SUB_LS_CLR) |=> !s_ff.fl.light_sleep_enabled)
    else $error("light sleep not cleared");
  status_fmt_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (exec_view() && s_ff.sub == SUB_STATUS) |=> control_status_word_out[15] == 1'b0)
    else $error("reserved bit set");
  qen_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_ff.fl.capacity_update_enable |=> s_ff.fl.capacity_update_enable)
    else $error("capacity enable cleared");
  oc_done_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(s_ff.fl.open_circuit_done) |-> $past(s_ff.pack)) else $error("oc done without pack");
  ret_stable_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (!exec_view() && !s_ff.bcal_run && !s_ff.ical_run) |=> $stable(control_status_word_out))
    else $error("return word changed");

  function automatic logic exec_view();
    exec_view = stop_c && s_ff.nbyte == 2'h3 && !s_ff.rd && s_ff.ptr == CMD_CTRL_LO;
  endfunction

endmodule

// File: design/gcsd_pkg.sv
/*
  Package for the gauge control subcommand decoder: command codes, subcommand
  codes, status bit positions, timing constants and the shared structs.
  Assumes a 25 MHz system clock and an I2C link sampled by that clock.
*/
package gcsd_pkg;

  // System clock
  localparam int unsigned CLK_HZ = 25000000;

  // Control word command codes (low and high data byte)
  localparam logic [7:0] CMD_CTRL_LO = 8'h00;
  localparam logic [7:0] CMD_CTRL_HI = 8'h01;
  localparam logic [6:0] DEV_ADDR    = 7'h55;

  // Subcommand codes
  localparam logic [15:0] SUB_STATUS    = 16'h0000;
  localparam logic [15:0] SUB_PART      = 16'h0001;
  localparam logic [15:0] SUB_FW_REV    = 16'h0002;
  localparam logic [15:0] SUB_SI_REV    = 16'h0003;
  localparam logic [15:0] SUB_SUM       = 16'h0004;
  localparam logic [15:0] SUB_ECHO      = 16'h0007;
  localparam logic [15:0] SUB_CHEM      = 16'h0008;
  localparam logic [15:0] SUB_BOARD_CAL = 16'h0009;
  localparam logic [15:0] SUB_INT_CAL   = 16'h000a;
  localparam logic [15:0] SUB_OFS_STORE = 16'h000b;
  localparam logic [15:0] SUB_OC_SAMPLE = 16'h000c;
  localparam logic [15:0] SUB_PACK_IN   = 16'h000d;
  localparam logic [15:0] SUB_PACK_OUT  = 16'h000e;
  localparam logic [15:0] SUB_DS_SET    = 16'h0011;
  localparam logic [15:0] SUB_DS_CLR    = 16'h0012;
  localparam logic [15:0] SUB_LS_SET    = 16'h0013;
  localparam logic [15:0] SUB_LS_CLR    = 16'h0014;
  localparam logic [15:0] SUB_RESTORE   = 16'h0015;
  localparam logic [15:0] SUB_LOCK      = 16'h0020;
  localparam logic [15:0] SUB_ALG_EN    = 16'h0021;
  localparam logic [15:0] SUB_CAL_MODE  = 16'h0040;
  localparam logic [15:0] SUB_RESET     = 16'h0041;

  // Identity values, arbitrary
  localparam logic [15:0] PART_KIND_VAL = 16'h1234;
  localparam logic [15:0] FW_REV_VAL    = 16'h0101;
  localparam logic [15:0] SI_REV_VAL    = 16'h0011;
  localparam logic [15:0] CHEMISTRY_ID_QUERY_VAL   = 16'h0100;

  // Status word bit positions
  localparam int unsigned ST_FAS  = 14;
  localparam int unsigned ST_LOCK = 13;
  localparam int unsigned ST_CSV  = 12;
  localparam int unsigned ST_CCA  = 11;
  localparam int unsigned ST_BCA  = 10;
  localparam int unsigned ST_OCD  = 9;
  localparam int unsigned ST_OCF  = 8;

  // Timing
  localparam int unsigned CCA_DELAY_S  = 225;
  localparam int unsigned BCAL_S       = 32;
  localparam int unsigned ICAL_S       = 16;
  localparam longint unsigned CCA_CYC  = longint'(CCA_DELAY_S) * CLK_HZ;
  localparam longint unsigned BCAL_CYC = longint'(BCAL_S) * CLK_HZ;
  localparam longint unsigned ICAL_CYC = longint'(ICAL_S) * CLK_HZ;
  localparam int unsigned CCA_RUN_CYC  = 16;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [2:0] {
    LS_IDLE = 3'b000,
    LS_ADDR = 3'b001,
    LS_ACK  = 3'b010,
    LS_DATA = 3'b011,
    LS_TX   = 3'b100,
    LS_TACK = 3'b101
  } gcsd_link_st_t;

  typedef struct packed {
    logic full_locked;
    logic locked;
    logic sum_valid;
    logic counter_cal_active;
    logic board_cal_active;
    logic open_circuit_done;
    logic open_circuit_fail;
    logic init_done;
    logic deep_sleep_req;
    logic light_sleep_enabled;
    logic sleep;
    logic constant_power_mode;
    logic resistance_update_disable;
    logic voltage_ok_for_capacity;
    logic capacity_update_enable;
  } gcsd_flags_t;

  typedef struct packed {
    logic init_done;
    logic sleep;
    logic constant_power_mode;
    logic resistance_update_disable;
    logic voltage_bad;
    logic pack_detect;
    logic insertion_detect_enable;
    logic oc_sample_ok;
    logic oc_sample_high_current;
    logic [15:0] flash_sum;
    logic [15:0] board_offset_meas;
    logic [15:0] counter_offset_meas;
  } gcsd_core_in_t;

endpackage

// File: bench/gcsd_host.sv
/*
  Host model: an I2C master that writes subcommands to the control word
  and reads the returned word back.
  Assumes a pull-up on SDA and an SCL period of 320 ns.
*/
`timescale 1ns/10ps
module gcsd_host
  import gcsd_pkg::*;
(
  // I2C lines
  output logic      scl_out,
  output logic      sda_drv_out,
  input  wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  task automatic bit_out(input logic b);
    #40 sda_drv_out = b;
    #120 scl_out = 1'b1;
    #160 scl_out = 1'b0;
  endtask
  task automatic byte_out(input logic [7:0] b, inout logic ok);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    #40 sda_drv_out = 1'b1;
    #120 scl_out = 1'b1;
    #80 ok = ok & ~sda_in;
    #80 scl_out = 1'b0;
  endtask
  task automatic byte_in(input logic last, output logic [7:0] b);
    // Let go of SDA after our own acknowledge so the device can drive
    #40 sda_drv_out = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #160 scl_out = 1'b1;
      #80 b[i] = sda_in;
      #80 scl_out = 1'b0;
    end
    bit_out(last);
  endtask
  // Serves as start and repeated start
  task automatic start();
    #40 sda_drv_out = 1'b1;
    #120 scl_out = 1'b1;
    #160 sda_drv_out = 1'b0;
    #160 scl_out = 1'b0;
  endtask
  // SCL stands high between frames
  task automatic stop();
    #40 sda_drv_out = 1'b0;
    #120 scl_out = 1'b1;
    #160 sda_drv_out = 1'b1;
    #320;
  endtask
  task automatic write_sub(input logic [15:0] code, output logic ok);
    ok = 1'b1;
    start();
    byte_out({DEV_ADDR, 1'b0}, ok);
    byte_out(CMD_CTRL_LO, ok);
    byte_out(code[7:0], ok);
    byte_out(code[15:8], ok);
    stop();
  endtask
  task automatic read_word(output logic [15:0] w, output logic ok);
    ok = 1'b1;
    start();
    byte_out({DEV_ADDR, 1'b0}, ok);
    byte_out(CMD_CTRL_LO, ok);
    start();
    byte_out({DEV_ADDR, 1'b1}, ok);
    byte_in(1'b0, w[7:0]);
    byte_in(1'b1, w[15:8]);
    stop();
  endtask
endmodule

// File: bench/test_gauge_control_subcommand_decoder.sv
/*
  Testbench of the subcommand decoder with the I2C host model.
  Assumes the decoder's timers are shortened through its parameters.
*/
`timescale 1ns/10ps
module test_gauge_control_subcommand_decoder;
  import gcsd_pkg::*;
  logic          sys_clk_in;
  logic          rst_n_in;
  gcsd_core_in_t core_in;
  logic          scl;
  logic          host_sda;
  wire           sda_line;
  logic          sda_out;
  logic          sda_oe_n_out;
  logic [5:0]    pul;
  logic [5:0]    seen;
  logic          pack;
  logic [15:0]   wd;
  logic [15:0]   rd;
  logic [15:0]   sum_val;
  logic [15:0]   ofs_val;
  logic          ok;
  gcsd_flags_t   ef;
  int            miscompares;
  int            checks;
  int            cycles;

  assign sda_line = host_sda & (sda_oe_n_out | sda_out);
  always #20 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    seen <= seen | pul;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      complete_run();
    end
  end

  gcsd_decoder #(.CCA_DELAY(100), .BCAL_TIME(50), .ICAL_TIME(30)) gcsd_decoder_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .core_in(core_in),
    .flash_sum_start_out(pul[5]), .oc_sample_req_out(pul[4]), .restore_out(pul[3]),
    .cal_mode_out(pul[2]), .full_reset_out(pul[1]), .offset_store_out(pul[0]),
    .pack_present_flag_out(pack), .control_status_word_out(wd));
  gcsd_host gcsd_host_i (.scl_out(scl), .sda_drv_out(host_sda), .sda_in(sda_line));

  task automatic complete_run();
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic send(input logic [15:0] c);
    @(negedge sys_clk_in);
    seen = 6'h00;
    gcsd_host_i.write_sub(c, ok);
    chk("ack", 16'h0001, {15'h0000, ok});
    repeat (4) @(negedge sys_clk_in);
  endtask
  // Counter calibration bit is masked: its moment depends on init timing
  function automatic logic [15:0] stat();
    gcsd_flags_t f;
    f = ef;
    f.init_done = core_in.init_done;
    f.sleep = core_in.sleep;
    f.constant_power_mode = core_in.constant_power_mode;
    f.resistance_update_disable = core_in.resistance_update_disable;
    return {1'b0, f} & 16'hf7ff;
  endfunction
  task automatic status();
    send(SUB_STATUS);
    chk("status", stat(), wd & 16'hf7ff);
  endtask
  task automatic rnd_core();
    @(negedge sys_clk_in);
    {core_in.sleep, core_in.constant_power_mode, core_in.resistance_update_disable} = 3'($urandom);
    core_in.voltage_bad = 1'($urandom);
    if (core_in.voltage_bad) ef.voltage_ok_for_capacity = 1'b0;
    core_in.flash_sum = 16'($urandom);
    core_in.board_offset_meas = 16'($urandom);
    core_in.counter_offset_meas = 16'($urandom);
  endtask
  task automatic pulse_oc(input logic high);
    @(negedge sys_clk_in);
    if (high) core_in.oc_sample_high_current = 1'b1;
    else core_in.oc_sample_ok = 1'b1;
    @(negedge sys_clk_in);
    core_in.oc_sample_high_current = 1'b0;
    core_in.oc_sample_ok = 1'b0;
  endtask

  initial begin
    sys_clk_in = 1'b0;
    rst_n_in = 1'b0;
    core_in = '0;
    seen = 6'h00;
    ef = '0;
    miscompares = 0;
    checks = 0;
    cycles = 0;
    void'($urandom(58));
    repeat (3) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    chk("word_rst", RST_WORD, wd);
    chk("oe_rst", 16'h0001, {15'h0000, sda_oe_n_out});
    core_in.pack_detect = 1'b1;
    repeat (2) begin
      rnd_core();
      status();
    end
    send(SUB_PART);
    chk("part", PART_KIND_VAL, wd);
    send(SUB_FW_REV);
    chk("fw", FW_REV_VAL, wd);
    send(SUB_SI_REV);
    chk("si", SI_REV_VAL, wd);
    send(SUB_CHEM);
    chk("chem", CHEMISTRY_ID_QUERY_VAL, wd);
    rnd_core();
    sum_val = core_in.flash_sum;
    send(SUB_SUM);
    chk("sum", sum_val, wd);
    chk("sum_go", 16'h0001, {15'h0000, seen[5]});
    ef.sum_valid = 1'b1;
    send(SUB_ECHO);
    chk("echo", SUB_SUM, wd);
    gcsd_host_i.read_word(rd, ok);
    chk("i2c_rd", SUB_SUM, rd);
    chk("rd_keep", SUB_SUM, wd);
    for (int i = 0; i < 4; i++) begin
      send(SUB_DS_SET + 16'(i));
      if (i < 2) ef.deep_sleep_req = (i == 0);
      else ef.light_sleep_enabled = (i == 2);
      status();
    end
    send(SUB_PACK_OUT);
    chk("pack_out", 16'h0000, {15'h0000, pack});
    send(SUB_PACK_IN);
    chk("pack_in", 16'h0001, {15'h0000, pack});
    core_in.init_done = 1'b1;
    send(SUB_OC_SAMPLE);
    chk("oc_req", 16'h0001, {15'h0000, seen[4]});
    pulse_oc(1'b0);
    ef.open_circuit_done = 1'b1;
    status();
    send(SUB_OC_SAMPLE);
    pulse_oc(1'b1);
    ef.open_circuit_fail = 1'b1;
    status();
    send(SUB_RESTORE);
    chk("restore", 16'h0008, {10'h000, seen});
    send(SUB_OFS_STORE);
    chk("store", 16'h0001, {10'h000, seen});
    send(SUB_CAL_MODE);
    chk("cal", 16'h0004, {10'h000, seen});
    send(SUB_ALG_EN);
    ef.capacity_update_enable = 1'b1;
    ef.voltage_ok_for_capacity = ~core_in.voltage_bad;
    status();
    send(SUB_BOARD_CAL);
    ofs_val = core_in.board_offset_meas;
    repeat (60) @(negedge sys_clk_in);
    chk("board", ofs_val, wd);
    ef.board_cal_active = 1'b1;
    status();
    send(SUB_INT_CAL);
    repeat (40) @(negedge sys_clk_in);
    chk("int_cal", core_in.counter_offset_meas, wd);
    status();
    send(16'h0016 + 16'($urandom % 10));
    chk("unknown", stat(), wd & 16'hf7ff);
    send(SUB_LOCK);
    ef.locked = 1'b1;
    status();
    rnd_core();
    send(SUB_SUM);
    chk("sum_lk", sum_val, wd);
    chk("sum_lk_go", 16'h0000, {10'h000, seen});
    send(SUB_BOARD_CAL);
    repeat (60) @(negedge sys_clk_in);
    chk("board_lk", ofs_val, wd);
    send(SUB_RESTORE);
    chk("lk_restore", 16'h0000, {10'h000, seen});
    send(SUB_CAL_MODE);
    chk("lk_cal", 16'h0000, {10'h000, seen});
    send(SUB_RESET);
    chk("lk_reset", 16'h0000, {10'h000, seen});
    send(SUB_DS_SET);
    ef.deep_sleep_req = 1'b1;
    status();
    rst_n_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    ef = '0;
    status();
    send(SUB_RESET);
    chk("reset", 16'h0002, {10'h000, seen});
    complete_run();
  end
endmodule
